// file: testbench/dsw_link_chk.sv
/* Assertions on the wires of the link that joins the two design ends.
   Assumes the bench clock and reset, and the link wires as inputs. */
module dsw_link_chk (
	// Clock and reset
	input logic clk,
	input logic rst,
	// Link wires
	input logic serial_clk,
	input logic serial_data_in,
	input logic frame_sync_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] falls_reg;
	logic [4:0] falls_next;
	logic       sclk_reg;
	// ------
	// Falling shift-clock edges seen in the current frame
	// ------
	always_comb begin
		falls_next = falls_reg + {4'h0, sclk_reg & ~serial_clk};
		if (frame_sync_n || rst)
			falls_next = 5'h00;
	end
	always_ff @(posedge clk) begin
		falls_reg <= falls_next;
		sclk_reg  <= serial_clk;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_park; frame_sync_n |-> serial_clk; endproperty
	property p_half; !frame_sync_n && $changed(serial_clk)
		|=> $stable(serial_clk)[*3]; endproperty
	property p_data; !frame_sync_n && !serial_clk
		|-> $stable(serial_data_in); endproperty
	property p_count; $rose(frame_sync_n) |-> falls_reg == 5'h10; endproperty
	property p_over; falls_reg <= 5'h10; endproperty
	property p_gap; $rose(frame_sync_n) |-> frame_sync_n[*3]; endproperty
	property p_len; $fell(frame_sync_n)
		|-> ##[120:140] $rose(frame_sync_n); endproperty
	property p_setup; $fell(frame_sync_n) |-> serial_clk[*3]; endproperty
	a_park: assert property (p_park)
		else $error("shift clock not parked high");
	a_half: assert property (p_half)
		else $error("shift clock half period too short");
	a_data: assert property (p_data)
		else $error("data moved while shift clock low");
	a_count: assert property (p_count)
		else $error("frame ended without 16 falls");
	a_over: assert property (p_over)
		else $error("more than 16 falls in a frame");
	a_gap: assert property (p_gap)
		else $error("frames too close");
	a_len: assert property (p_len)
		else $error("frame length out of range");
	a_setup: assert property (p_setup)
		else $error("no setup before first fall");
	cover property ($rose(frame_sync_n));
	cover property ($rose(frame_sync_n) ##[3:8] $fell(frame_sync_n));
	cover property (falls_reg == 5'h10);
endmodule

// file: testbench/dsw_serial_write_port_bench.sv
/* Bench: the host end drives the device end over link_a; the bench
   drives link_b itself to break framing against a second device.
   Assumes the design files and the checker are compiled first. */
module dds_serial_write_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsw_pkg::*;
	logic          clk, rst, ce, word_valid, word_ready, busy;
	logic          fsel, psel, str_a, str_b, saw_full;
	logic [3:0]    ctrl_a, addr_a;
	logic [7:0]    pay_a;
	logic [31:0]   seed;
	dsw_word_type  word_data, last_a, exp_q[$];
	dsw_freq_type  freq_a, freq_b;
	dsw_phase_type phase_a;
	dsw_freq_type  f_m[2] = '{14'h0000, 14'h0000};
	dsw_phase_type p_m[2] = '{12'h000, 12'h000};
	int            errors, n_tests, cycles, nb;
	localparam dsw_word_type corner[6] = '{16'h0000, 16'h7FFF,
		16'h8001, 16'hC0AB, 16'hEFFF, 16'h3FFF};
	dsw_link_if link_a ();
	dsw_link_if link_b ();
	dsw_host u_dsw_host (.clk(clk), .rst(rst), .ce(ce),
		.word_data(word_data), .word_valid(word_valid),
		.word_ready(word_ready), .busy(busy), .link(link_a));
	dsw_device u_dsw_device (.clk(clk), .rst(rst), .ce(ce),
		.link(link_a), .freq_reg_select_pin(fsel),
		.phase_reg_select_pin(psel), .active_freq(freq_a),
		.active_phase(phase_a), .last_word(last_a), .word_strobe(str_a),
		.word_ctrl(ctrl_a), .word_addr(addr_a), .word_payload(pay_a));
	dsw_device u_dsw_device_2 (.clk(clk), .rst(rst), .ce(ce),
		.link(link_b), .freq_reg_select_pin(fsel),
		.phase_reg_select_pin(psel), .active_freq(freq_b),
		.active_phase(), .last_word(), .word_strobe(str_b),
		.word_ctrl(), .word_addr(), .word_payload());
	dsw_link_chk u_dsw_link_chk (.clk(clk), .rst(rst),
		.serial_clk(link_a.serial_clk),
		.serial_data_in(link_a.serial_data_in),
		.frame_sync_n(link_a.frame_sync_n));
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic void model(dsw_word_type w);
		case (w[15:14])
			2'h1: f_m[0] = w[13:0];
			2'h2: f_m[1] = w[13:0];
			2'h3: p_m[w[13]] = w[11:0];
			default: ;
		endcase
	endfunction
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (exp !== got) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic push(dsw_word_type w);
		@(negedge clk);
		word_data = w;
		word_valid = 1'b1;
		do @(posedge clk); while (word_ready !== 1'b1);
		exp_q.push_back(w);
	endtask
	task automatic drain();
		@(negedge clk);
		word_valid = 1'b0;
		while (exp_q.size() != 0 || busy !== 1'b0)
			@(negedge clk);
		chk("idle", 16'h0001, {14'h0000, busy, word_ready});
		for (int i = 0; i < 4; i++) begin
			{fsel, psel} = i[1:0];
			repeat (6) @(negedge clk);
			chk("freq", {2'h0, f_m[fsel]}, {2'h0, freq_a});
			chk("phase", {4'h0, p_m[psel]}, {4'h0, phase_a});
		end
	endtask
	// Clock of link_b unrelated in phase to clk
	task automatic ser_b(dsw_word_type w, int n, logic idle);
		link_b.serial_clk = idle;
		#213 link_b.frame_sync_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#200 link_b.serial_clk = 1'b1;
			link_b.serial_data_in = w[15 - i];
			#200 link_b.serial_clk = 1'b0;
		end
		#200 link_b.serial_clk = idle;
		link_b.frame_sync_n = 1'b1;
		// Released line must not look held
		link_b.serial_data_in = ~link_b.serial_data_in;
		repeat (8) @(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			errors++;
			summarize();
		end
	end
	always @(negedge clk) begin
		if (word_valid === 1'b1 && word_ready === 1'b0)
			saw_full = 1'b1;
		if (str_b === 1'b1)
			nb++;
		if (str_a === 1'b1) begin
			if (exp_q.size() == 0)
				exp_q.push_back(16'hXXXX);
			chk("word", exp_q[0], last_a);
			chk("fields", exp_q[0], {ctrl_a, addr_a, pay_a});
			model(exp_q.pop_front());
		end
	end
	initial begin
		{ce, rst, word_valid, fsel, psel, saw_full} = 6'h30;
		word_data = 16'h0000;
		seed = 32'h00014B3C;
		link_b.serial_clk = 1'b1;
		link_b.frame_sync_n = 1'b1;
		link_b.serial_data_in = 1'b0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		foreach (corner[i])
			push(corner[i]);
		drain();
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			push(seed[15:0]);
		end
		drain();
		chk("full", 16'h0001, {15'h0000, saw_full});
		{fsel, psel} = 2'h0;
		ser_b(16'h4321, 10, 1'b0);
		chk("short", 16'h0000, {nb[1:0], freq_b});
		ser_b(16'h5A5A, 16, 1'b0);
		chk("low park", 16'h5A5A, {nb[1:0], freq_b});
		ser_b(16'h7FFF, 12, 1'b1);
		chk("short high", 16'h5A5A, {nb[1:0], freq_b});
		summarize();
	end
endmodule

// file: verilog/dsw_device.sv
/*
 * Device end: receives 16-bit words on the three-wire link, decodes
 * them into two frequency and two phase registers, and selects one
 * of each from pins for keying.
 * Assumes link pins are asynchronous to clk and slow against it.
 */
`include "dsw_regs.svh"

// Summary of operation
// - Shift clock up to 40 MHz accepted; this end only sees edges of a shift clock slow against clk
// - Free-running or parked clock corrupts nothing
// - Host holds frame low for all 16 bits
// - One frame low period is one word
// - Data sampled on shift-clock falling edges
// - Byte hosts keep frame low across two bytes
// - First bit received is the MSB
// - Word splits control, address, eight-bit payload
// - Active-high frame syncs are inverted by host
// - Select pin chooses active frequency register
// - Two phase registers, selected one applied
// - Top bits 11 write phase, bit 13 picks
module dsw_device
	import dsw_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ce,
	// Link
	dsw_link_if.dev_mp         link,
	// Keying pins
	input  wire logic          freq_reg_select_pin,
	input  wire logic          phase_reg_select_pin,
	// Results
	output dsw_pkg::dsw_freq_type  active_freq,
	output dsw_pkg::dsw_phase_type active_phase,
	output dsw_pkg::dsw_word_type  last_word,
	output logic               word_strobe,
	output logic [3:0]         word_ctrl,
	output logic [3:0]         word_addr,
	output logic [7:0]         word_payload
);
	import dsw_pkg::*;

	// ------------------------------------------------------------------
	// Synchronisers, two flops on every outside input
	// ------------------------------------------------------------------
	logic [4:0] s1_reg, s2_reg, s1_next, s2_next;
	logic       sclk_prev_reg, sclk_prev_next;

	always_comb begin
		s1_next = {phase_reg_select_pin, freq_reg_select_pin,
			link.frame_sync_n, link.serial_data_in, link.serial_clk};
		s2_next = s1_reg;
		sclk_prev_next = s2_reg[0];
	end

	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	dsw_word_type sh_reg, sh_next;
	logic [4:0]   cnt_reg, cnt_next;
	logic         got_reg, got_next;
	logic         fall, frame;

	// Edges inside a frame only, so idle clock parks harmlessly
	assign fall  = sclk_prev_reg && !s2_reg[0];
	assign frame = !s2_reg[2];

	always_comb begin
		sh_next  = sh_reg;
		cnt_next = cnt_reg;
		got_next = 1'b0;
		if (!frame) begin
			// Short or aborted frame just resets the count
			cnt_next = 5'h0;
		end else if (fall && cnt_reg != 5'(`DSW_WORD_BITS)) begin
			sh_next  = {sh_reg[`DSW_WORD_BITS-2:0], s2_reg[1]};
			cnt_next = cnt_reg + 5'h1;
			// Sixteenth edge completes the word; later edges ignored
			got_next = (cnt_reg == 5'(`DSW_WORD_BITS - 1));
		end
	end

	// Synchroniser flops; reset loads clock, data and frame high and both select pins low
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg  <= 5'h07;
			s2_reg  <= 5'h07;
			sclk_prev_reg <= 1'b1;
		end else if (ce) begin
			s1_reg  <= s1_next;
			s2_reg  <= s2_next;
			sclk_prev_reg <= sclk_prev_next;
		end
	end

	// Shift register and bit count
	always_ff @(posedge clk) begin
		if (rst) begin
			sh_reg  <= '0;
			cnt_reg <= 5'h0;
			got_reg <= 1'b0;
		end else if (ce) begin
			sh_reg  <= sh_next;
			cnt_reg <= cnt_next;
			got_reg <= got_next;
		end
	end

	// ------------------------------------------------------------------
	// Decode of the accepted word
	// ------------------------------------------------------------------
	logic [1:0] kind;
	logic       is_phase, is_freq0, is_freq1;
	logic [1:0] f_load, p_load;

	always_comb begin
		kind     = sh_reg[`DSW_CTRL_MSB -: 2];
		is_phase = got_reg && (kind == `DSW_PHASE_CODE);
		is_freq0 = got_reg && (kind == `DSW_FREQ0_CODE);
		is_freq1 = got_reg && (kind == `DSW_FREQ1_CODE);
		// Control words load nothing; they only reach the fields
		f_load   = {is_freq1, is_freq0};
		p_load   = {is_phase && sh_reg[`DSW_PHASE_SEL_BIT],
			is_phase && !sh_reg[`DSW_PHASE_SEL_BIT]};
	end

	// ------------------------------------------------------------------
	// Register bank, one frequency and one phase entry per index
	// ------------------------------------------------------------------
	dsw_freq_type  f_reg [2];
	dsw_freq_type  f_next [2];
	dsw_phase_type p_reg [2];
	dsw_phase_type p_next [2];

	for (genvar gi = 0; gi < 2; gi++) begin : g_bank
		// Each entry loads only from a whole word; partial frames
		// never raise a load, so the entry keeps its value
		always_comb begin
			f_next[gi] = f_reg[gi];
			p_next[gi] = p_reg[gi];
			if (f_load[gi])
				f_next[gi] = sh_reg[`DSW_FREQ_BITS-1:0];
			if (p_load[gi])
				p_next[gi] = sh_reg[`DSW_PHASE_BITS-1:0];
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				f_reg[gi] <= `DSW_FREQ_RESET;
				p_reg[gi] <= `DSW_PHASE_RESET;
			end else if (ce) begin
				f_reg[gi] <= f_next[gi];
				p_reg[gi] <= p_next[gi];
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	dsw_freq_type  act_f_next;
	dsw_phase_type act_p_next;

	// Selection reads next values, so a fresh load shows one cycle early
	always_comb begin
		act_f_next = f_next[s2_reg[3]];
		act_p_next = p_next[s2_reg[4]];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			active_freq  <= `DSW_FREQ_RESET;
			active_phase <= `DSW_PHASE_RESET;
			last_word    <= '0;
			word_strobe  <= 1'b0;
			word_ctrl    <= 4'h0;
			word_addr    <= 4'h0;
			word_payload <= 8'h00;
		end else if (ce) begin
			active_freq  <= act_f_next;
			active_phase <= act_p_next;
			word_strobe  <= got_reg;
			if (got_reg) begin
				last_word    <= sh_reg;
				// Field split of the accepted word
				word_ctrl    <= sh_reg[`DSW_CTRL_MSB:`DSW_CTRL_LSB];
				word_addr    <= sh_reg[`DSW_ADDR_MSB:`DSW_ADDR_LSB];
				word_payload <= sh_reg[`DSW_DATA_MSB:`DSW_DATA_LSB];
			end
		end
	end
endmodule

// file: verilog/dsw_host.sv
/*
 * Host end: takes 16-bit words through a two-entry buffer and shifts
 * them MSB first with an active-low frame per word.
 * Assumes one clock clk; shift clock made by a divider of clk.
 */
`include "dsw_regs.svh"

module dsw_host
	import dsw_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ce,
	// Word stream in
	input  wire dsw_pkg::dsw_word_type word_data,
	input  wire logic          word_valid,
	output logic               word_ready,
	output logic               busy,
	// Link
	dsw_link_if.host_mp        link
);
	import dsw_pkg::*;

	// ------------------------------------------------------------------
	// Two-entry buffer
	// ------------------------------------------------------------------
	dsw_word_type buf_reg [2];
	dsw_word_type buf_next [2];
	logic [1:0]   cnt_reg, cnt_next;
	logic         rd_reg, rd_next, wr_reg, wr_next;
	logic         pop;

	always_comb begin
		buf_next = buf_reg;
		cnt_next = cnt_reg;
		rd_next  = rd_reg;
		wr_next  = wr_reg;
		if (word_valid && cnt_reg != 2'h2) begin
			buf_next[wr_reg] = word_data;
			wr_next = ~wr_reg;
		end
		if (pop)
			rd_next = ~rd_reg;
		cnt_next = cnt_reg + {1'b0, word_valid && cnt_reg != 2'h2}
			- {1'b0, pop};
	end

	// ------------------------------------------------------------------
	// Shifter; words leave MSB first, data changes on rising edges
	// ------------------------------------------------------------------
	dsw_host_state_type st_reg, st_next;
	dsw_word_type sh_reg, sh_next;
	logic [4:0]   bit_reg, bit_next;
	logic [`DSW_HALF_CNT_W-1:0] div_reg, div_next;
	logic sclk_reg, sclk_next, fs_reg, fs_next, sd_reg, sd_next;
	logic tick;

	assign tick = (div_reg == 3'(`DSW_SCLK_HALF_CYC - 1));
	// Start only on a divider tick, so frames stay apart by >= 3 cycles
	assign pop  = (st_reg == DSW_H_IDLE) && (cnt_reg != 2'h0) && tick;

	always_comb begin
		st_next   = st_reg;
		sh_next   = sh_reg;
		bit_next  = bit_reg;
		div_next  = tick ? 3'h0 : div_reg + 3'h1;
		sclk_next = sclk_reg;
		fs_next   = fs_reg;
		sd_next   = sd_reg;
		case (st_reg)
			DSW_H_IDLE: begin
				if (pop) begin
					// Frame low for the whole word
					fs_next  = 1'b0;
					sh_next  = buf_reg[rd_reg] << 1;
					sd_next  = buf_reg[rd_reg][`DSW_WORD_BITS-1];
					bit_next = 5'h0;
					st_next  = DSW_H_HIGH;
				end
			end
			DSW_H_HIGH: if (tick) begin
				// Falling edge, device samples; clock <= 2.5 MHz
				sclk_next = 1'b0;
				bit_next  = bit_reg + 5'h1;
				st_next   = DSW_H_LOW;
			end
			DSW_H_LOW: if (tick) begin
				sclk_next = 1'b1;
				if (bit_reg == 5'(`DSW_WORD_BITS))
					st_next = DSW_H_END;
				else begin
					sd_next = sh_reg[`DSW_WORD_BITS-1];
					sh_next = sh_reg << 1;
					st_next = DSW_H_HIGH;
				end
			end
			DSW_H_END: if (tick) begin
				fs_next = 1'b1;
				st_next = DSW_H_IDLE;
			end
			default: st_next = DSW_H_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			cnt_reg  <= 2'h0;
			rd_reg   <= 1'b0;
			wr_reg   <= 1'b0;
			st_reg   <= DSW_H_IDLE;
			sh_reg   <= '0;
			bit_reg  <= 5'h0;
			div_reg  <= 3'h0;
			sclk_reg <= 1'b1;
			fs_reg   <= 1'b1;
			sd_reg   <= 1'b0;
			word_ready <= 1'b0;
			busy     <= 1'b0;
		end else if (ce) begin
			buf_reg  <= buf_next;
			cnt_reg  <= cnt_next;
			rd_reg   <= rd_next;
			wr_reg   <= wr_next;
			st_reg   <= st_next;
			sh_reg   <= sh_next;
			bit_reg  <= bit_next;
			div_reg  <= div_next;
			sclk_reg <= sclk_next;
			fs_reg   <= fs_next;
			sd_reg   <= sd_next;
			// Registered ready: room for one more after this cycle
			word_ready <= (cnt_next != 2'h2);
			busy     <= (cnt_next != 2'h0) || (st_next != DSW_H_IDLE);
		end
	end

	// Active-high frame never leaves this end
	assign link.serial_clk     = sclk_reg;
	assign link.frame_sync_n   = fs_reg;
	assign link.serial_data_in = sd_reg;
endmodule

// file: verilog/dsw_link_if.sv
/*
 * Three-wire link between host (master) and synthesiser (slave).
 * Assumes both ends share the wires; no clocking block.
 */
interface dsw_link_if;
	logic serial_clk;
	logic serial_data_in;
	logic frame_sync_n;

	modport host_mp (
		output serial_clk,
		output serial_data_in,
		output frame_sync_n
	);
	modport dev_mp (
		input serial_clk,
		input serial_data_in,
		input frame_sync_n
	);
endinterface

// file: verilog/dsw_pkg.sv
/*
 * Types shared by both ends of the serial write port.
 * Assumes dsw_regs.svh is on the include path.
 */
`include "dsw_regs.svh"

package dsw_pkg;
	typedef logic [`DSW_WORD_BITS-1:0]  dsw_word_type;
	typedef logic [`DSW_FREQ_BITS-1:0]  dsw_freq_type;
	typedef logic [`DSW_PHASE_BITS-1:0] dsw_phase_type;
	typedef enum logic [1:0] {
		DSW_H_IDLE,
		DSW_H_LOW,
		DSW_H_HIGH,
		DSW_H_END
	} dsw_host_state_type;
endpackage

// file: verilog/dsw_regs.svh
/*
 * Constants for the serial write port of the synthesiser: word layout,
 * field positions, reset values and link timing counts.
 * Assumes inclusion by bare name from the package and both ends.
 */
`ifndef DSW_REGS_SVH
`define DSW_REGS_SVH

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define DSW_WORD_BITS      16
`define DSW_CTRL_MSB       15
`define DSW_CTRL_LSB       12
`define DSW_ADDR_MSB       11
`define DSW_ADDR_LSB       8
`define DSW_DATA_MSB       7
`define DSW_DATA_LSB       0
`define DSW_PHASE_SEL_BIT  13
`define DSW_FREQ_SEL_BIT   14
`define DSW_PHASE_CODE     2'h3
`define DSW_FREQ0_CODE     2'h1
`define DSW_FREQ1_CODE     2'h2
`define DSW_FREQ_BITS      14
`define DSW_PHASE_BITS     12

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSW_FREQ_RESET     14'h0000
`define DSW_PHASE_RESET    12'h000

// ----------------------------------------------------------------------
// Timing: shift clock at most 40 MHz; host divides its 50 ns clock
// ----------------------------------------------------------------------
`define DSW_SCLK_MAX_MHZ   40
`define DSW_CLK_MHZ        20
`define DSW_SCLK_HALF_CYC  4
`define DSW_HALF_CNT_W     3

`endif
